/* File: logic/ebc_pkg.sv */
// constants for the external bus cycle sequencer: register map, field layout, limits
// assumes one phase time unit is a fixed whole number of sys_clk cycles
package ebc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] OFS_CFG0 = 8'h00;
    localparam logic [REG_AW-1:0] OFS_CFG1 = 8'h04;
    localparam logic [REG_AW-1:0] OFS_ADDR = 8'h08;
    localparam logic [REG_AW-1:0] OFS_WDATA = 8'h0c;
    localparam logic [REG_AW-1:0] OFS_CMD = 8'h10;
    localparam logic [REG_AW-1:0] OFS_STATUS = 8'h14;
    localparam logic [REG_AW-1:0] OFS_RDATA = 8'h18;

    // ----------------------------------------------------------------
    // bus widths and chip selects
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CS_NUM = 2;

    // ----------------------------------------------------------------
    // chip_select_timing_config field layout
    // ----------------------------------------------------------------
    localparam int CFG_W = 15;
    localparam int CFG_AB_POS = 0;   // address setup: 0 -> 1 unit, 1 -> 2 units
    localparam int CFG_ABX_POS = 1;  // extra setup units on window change, 2 bits
    localparam int CFG_C_POS = 3;    // command delay, 2 bits
    localparam int CFG_D_POS = 5;    // write setup / tristate, 1 bit
    localparam int CFG_E_POS = 6;    // access length minus one, 5 bits
    localparam int CFG_F_POS = 11;   // hold, 2 bits
    localparam int CFG_RDY_POS = 13; // ready handshake enable
    localparam int CFG_MUX_POS = 14; // multiplexed bus mode
    localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

    // ----------------------------------------------------------------
    // command register fields
    // ----------------------------------------------------------------
    localparam int CMD_RNW_POS = 0;
    localparam int CMD_CS_POS = 1;
    localparam int CMD_HBS_POS = 2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_NS = 25;
    localparam int UNIT_NS = 25;     // phase_time_unit
    localparam int UNIT_CYCLES = (UNIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int CNT_W = 8;
    localparam int AB_MAX = 5;
    localparam int E_MAX = 32;
endpackage

/* File: logic/phase_timer.sv */
// down counter that times one bus cycle phase
// assumes the caller loads length-in-cycles minus one on phase entry
`timescale 1ns/100ps
module phase_timer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [ebc_pkg::CNT_W-1:0] load_val,
    output logic done
);
    import ebc_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // count down and park at zero, so a held phase sees done steadily
    always_comb begin
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done = (cnt_r == '0);
endmodule

/* File: logic/ext_bus_seq.sv */
// external bus cycle sequencer: register port, phase machine and bus pins
// assumes pins are sampled synchronously; tristate resolution is done outside
`timescale 1ns/100ps
// Summary of operation
// - up to five phases in fixed order; command delay, write setup and hold are skipped at zero
// - phase lengths per chip select; delay 0..3
// - access 1..32 units, ready may stretch it
// - setup 1..2 units, plus 0..3 on window change
// - write setup or tristate gap 0..1 units
// - hold 0..3 units, address and write data driven
// - read data taken as read strobe rises
// - late address change cannot corrupt read data
// - multiplexed or separate address and data buses
module ext_bus_seq (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ebc_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ebc_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ebc_pkg::REG_DW-1:0] reg_rdata,
    output logic [ebc_pkg::ADDR_W-1:0] ext_addr,
    output logic [ebc_pkg::DATA_W-1:0] data_o,
    output logic data_oe,
    input wire logic [ebc_pkg::DATA_W-1:0] data_i,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [ebc_pkg::CS_NUM-1:0] cs_n,
    output logic high_byte_select_n,
    input wire logic ready
);
    import ebc_pkg::*;

    typedef enum logic [2:0] {PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_F} phase_t;

    // ----------------------------------------------------------------
    // phase length helpers
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] units(input phase_t ph, input logic [CFG_W-1:0] c,
                                               input logic win);
        logic [CNT_W-1:0] u;
        u = '0;
        unique case (ph)
            PH_IDLE: u = '0;
            PH_AB: u = CNT_W'(c[CFG_AB_POS]) + 8'h01 +
                       (win ? CNT_W'(c[CFG_ABX_POS +: 2]) : 8'h00);
            PH_C: u = CNT_W'(c[CFG_C_POS +: 2]);
            PH_D: u = CNT_W'(c[CFG_D_POS]);
            PH_E: u = CNT_W'(c[CFG_E_POS +: 5]) + 8'h01;
            PH_F: u = CNT_W'(c[CFG_F_POS +: 2]);
        endcase
        return u;
    endfunction

    // next phase in the fixed order, skipping phases of zero length
    function automatic phase_t after(input phase_t ph, input logic [CFG_W-1:0] c);
        phase_t p;
        p = PH_IDLE;
        unique case (ph)
            PH_IDLE: p = PH_AB;
            PH_AB: p = (c[CFG_C_POS +: 2] != 2'h0) ? PH_C : (c[CFG_D_POS] ? PH_D : PH_E);
            PH_C: p = c[CFG_D_POS] ? PH_D : PH_E;
            PH_D: p = PH_E;
            PH_E: p = (c[CFG_F_POS +: 2] != 2'h0) ? PH_F : PH_IDLE;
            PH_F: p = PH_IDLE;
        endcase
        return p;
    endfunction

    // ----------------------------------------------------------------
    // registers and transaction state
    // ----------------------------------------------------------------
    logic [CFG_W-1:0] cfg_r [CS_NUM];
    logic [CFG_W-1:0] cfg_nxt [CS_NUM];
    logic [ADDR_W-1:0] sw_addr_r, sw_addr_nxt;
    logic [DATA_W-1:0] sw_wdata_r, sw_wdata_nxt;
    logic [DATA_W-1:0] cap_r, cap_nxt;
    logic [REG_DW-1:0] rdata_r, rdata_nxt;
    logic [ADDR_W-1:0] t_addr_r, t_addr_nxt;
    logic [DATA_W-1:0] t_wdata_r, t_wdata_nxt;
    logic [CFG_W-1:0] t_cfg_r, t_cfg_nxt;
    logic t_rnw_r, t_rnw_nxt, t_cs_r, t_cs_nxt, t_hbs_r, t_hbs_nxt, t_win_r, t_win_nxt;
    logic last_cs_r, last_cs_nxt, last_ok_r, last_ok_nxt;
    phase_t state_r, state_nxt;
    logic tmr_load, tmr_done;
    logic [CNT_W-1:0] tmr_val;
    logic start;
    logic wait_rdy;

    // a command write while a cycle runs is dropped; software polls busy
    assign start = reg_wr && (reg_addr == OFS_CMD) && (state_r == PH_IDLE);

    // software register writes and read-back, data one cycle after the strobe
    always_comb begin
        for (int i = 0; i < CS_NUM; i++) begin
            cfg_nxt[i] = cfg_r[i];
            if (reg_wr && reg_addr == ((OFS_CFG1 - OFS_CFG0) * REG_AW'(i))) begin
                cfg_nxt[i] = reg_wdata[CFG_W-1:0];
            end
        end
        sw_addr_nxt = (reg_wr && reg_addr == OFS_ADDR) ? reg_wdata[ADDR_W-1:0] : sw_addr_r;
        sw_wdata_nxt = (reg_wr && reg_addr == OFS_WDATA) ? reg_wdata[DATA_W-1:0] : sw_wdata_r;
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CFG0: rdata_nxt = {{(REG_DW-CFG_W){1'b0}}, cfg_r[0]};
                OFS_CFG1: rdata_nxt = {{(REG_DW-CFG_W){1'b0}}, cfg_r[1]};
                OFS_ADDR: rdata_nxt = {{(REG_DW-ADDR_W){1'b0}}, sw_addr_r};
                OFS_WDATA: rdata_nxt = {{(REG_DW-DATA_W){1'b0}}, sw_wdata_r};
                OFS_STATUS: rdata_nxt = {{(REG_DW-1){1'b0}}, state_r != PH_IDLE};
                OFS_RDATA: rdata_nxt = {{(REG_DW-DATA_W){1'b0}}, cap_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CS_NUM; i++) begin
                cfg_r[i] <= CFG_RST;
            end
            sw_addr_r <= '0;
            sw_wdata_r <= '0;
            rdata_r <= '0;
        end else begin
            for (int i = 0; i < CS_NUM; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
            sw_addr_r <= sw_addr_nxt;
            sw_wdata_r <= sw_wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // phase machine
    // ----------------------------------------------------------------
    phase_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // access end is held off while ready handshake is enabled and absent
    assign wait_rdy = t_cfg_r[CFG_RDY_POS] && !ready;

    // latch the transaction at start so config writes cannot disturb a cycle
    always_comb begin
        t_addr_nxt = t_addr_r;
        t_wdata_nxt = t_wdata_r;
        t_cfg_nxt = t_cfg_r;
        t_rnw_nxt = t_rnw_r;
        t_cs_nxt = t_cs_r;
        t_hbs_nxt = t_hbs_r;
        t_win_nxt = t_win_r;
        last_cs_nxt = last_cs_r;
        last_ok_nxt = last_ok_r;
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_val = '0;
        cap_nxt = cap_r;
        if (start) begin
            t_addr_nxt = sw_addr_r;
            t_wdata_nxt = sw_wdata_r;
            t_rnw_nxt = reg_wdata[CMD_RNW_POS];
            t_cs_nxt = reg_wdata[CMD_CS_POS];
            t_hbs_nxt = reg_wdata[CMD_HBS_POS];
            t_cfg_nxt = cfg_r[reg_wdata[CMD_CS_POS]];
            t_win_nxt = !last_ok_r || (last_cs_r != reg_wdata[CMD_CS_POS]);
            last_cs_nxt = reg_wdata[CMD_CS_POS];
            last_ok_nxt = 1'b1;
            state_nxt = PH_AB;
        end else if (state_r != PH_IDLE && tmr_done && !(state_r == PH_E && wait_rdy)) begin
            state_nxt = after(state_r, t_cfg_r);
        end
        if (state_nxt != state_r && state_nxt != PH_IDLE) begin
            tmr_load = 1'b1;
            tmr_val = CNT_W'(units(state_nxt, t_cfg_nxt, t_win_nxt) * UNIT_CYCLES - 1);
        end
        // read data taken on the same edge that raises the read strobe
        if (state_r == PH_E && state_nxt != PH_E && t_rnw_r) begin
            cap_nxt = data_i;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            t_addr_r <= '0;
            t_wdata_r <= '0;
            t_cfg_r <= CFG_RST;
            t_rnw_r <= 1'b0;
            t_cs_r <= 1'b0;
            t_hbs_r <= 1'b0;
            t_win_r <= 1'b0;
            last_cs_r <= 1'b0;
            last_ok_r <= 1'b0;
            state_r <= PH_IDLE;
            cap_r <= '0;
        end else begin
            t_addr_r <= t_addr_nxt;
            t_wdata_r <= t_wdata_nxt;
            t_cfg_r <= t_cfg_nxt;
            t_rnw_r <= t_rnw_nxt;
            t_cs_r <= t_cs_nxt;
            t_hbs_r <= t_hbs_nxt;
            t_win_r <= t_win_nxt;
            last_cs_r <= last_cs_nxt;
            last_ok_r <= last_ok_nxt;
            state_r <= state_nxt;
            cap_r <= cap_nxt;
        end
    end

    // ----------------------------------------------------------------
    // bus pins, all registered from the next phase
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] ext_addr_nxt;
    logic [DATA_W-1:0] data_o_nxt;
    logic data_oe_nxt, ale_nxt, rd_n_nxt, wr_n_nxt, hbs_n_nxt;
    logic [CS_NUM-1:0] cs_n_nxt;
    logic act, mux, strobe_ph, data_ph;

    always_comb begin
        act = (state_nxt != PH_IDLE);
        mux = t_cfg_nxt[CFG_MUX_POS];
        strobe_ph = (state_nxt == PH_D) || (state_nxt == PH_E);
        data_ph = (state_nxt == PH_D) || (state_nxt == PH_E) || (state_nxt == PH_F);
        // address only moves at cycle start, so read data is never disturbed
        ext_addr_nxt = start ? t_addr_nxt : ext_addr;
        cs_n_nxt = '1;
        if (act) begin
            cs_n_nxt[t_cs_nxt] = 1'b0;
        end
        ale_nxt = mux && (state_nxt == PH_AB);
        rd_n_nxt = !(t_rnw_nxt && strobe_ph);
        wr_n_nxt = !(!t_rnw_nxt && strobe_ph);
        hbs_n_nxt = !(act && t_hbs_nxt);
        // shared lines carry address in setup, then float for reads
        data_oe_nxt = (mux && state_nxt == PH_AB) || (!t_rnw_nxt && data_ph);
        data_o_nxt = (mux && state_nxt == PH_AB) ? t_addr_nxt[DATA_W-1:0] : t_wdata_nxt;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_addr <= '0;
            data_o <= '0;
            data_oe <= 1'b0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= '1;
            high_byte_select_n <= 1'b1;
        end else begin
            ext_addr <= ext_addr_nxt;
            data_o <= data_o_nxt;
            data_oe <= data_oe_nxt;
            ale <= ale_nxt;
            rd_n <= rd_n_nxt;
            wr_n <= wr_n_nxt;
            cs_n <= cs_n_nxt;
            high_byte_select_n <= hbs_n_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [15:0] ph_cyc_r, len_now;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || state_nxt != state_r) begin
            ph_cyc_r <= 16'h0001;
        end else if (ph_cyc_r != 16'hffff) begin
            ph_cyc_r <= ph_cyc_r + 16'h0001;
        end
    end
    assign len_now = 16'(units(state_r, t_cfg_r, t_win_r) * UNIT_CYCLES);
    wire leaving = (state_r != PH_IDLE) && (state_nxt != state_r);
    // order checked by rank; a skipped phase must have been programmed to zero
    property p_order;
        @(posedge sys_clk) disable iff (!rst_n)
        leaving |-> (state_nxt == PH_IDLE ? state_r >= PH_E : state_nxt > state_r) &&
            !(state_r < PH_C && state_nxt > PH_C && t_cfg_r[CFG_C_POS +: 2] != 2'h0) &&
            !(state_r < PH_D && state_nxt > PH_D && t_cfg_r[CFG_D_POS]) &&
            (state_r >= PH_E || state_nxt <= PH_E) &&
            !(state_r == PH_E && state_nxt == PH_IDLE && t_cfg_r[CFG_F_POS +: 2] != 2'h0);
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");
    property p_len_fixed;
        @(posedge sys_clk) disable iff (!rst_n)
        (leaving && state_r != PH_E) |-> ph_cyc_r == len_now;
    endproperty
    a_len_fixed: assert property (p_len_fixed) else $error("phase length wrong");
    property p_access;
        @(posedge sys_clk) disable iff (!rst_n)
        (leaving && state_r == PH_E) |-> (ph_cyc_r >= len_now) &&
            (t_cfg_r[CFG_RDY_POS] || ph_cyc_r == len_now) && !wait_rdy;
    endproperty
    a_access: assert property (p_access) else $error("access length wrong");
    property p_setup_max;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_r == PH_AB) |-> ph_cyc_r <= 16'(AB_MAX * UNIT_CYCLES);
    endproperty
    a_setup_max: assert property (p_setup_max) else $error("setup too long");
    property p_capture;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rd_n) |-> cap_r == $past(data_i);
    endproperty
    a_capture: assert property (p_capture) else $error("read data not taken at strobe end");
    property p_addr_still;
        @(posedge sys_clk) disable iff (!rst_n)
        !rd_n ##1 !rd_n |-> $stable(ext_addr);
    endproperty
    a_addr_still: assert property (p_addr_still) else $error("address moved in read");
    property p_strobe;
        @(posedge sys_clk) disable iff (!rst_n)
        (!rd_n || !wr_n) |-> (state_r == PH_D || state_r == PH_E) && (rd_n != wr_n);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe outside setup and access");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_r == PH_F && !t_rnw_r) |-> data_oe && wr_n && data_o == t_wdata_r;
    endproperty
    a_hold: assert property (p_hold) else $error("write data not held");
    property p_mux;
        @(posedge sys_clk) disable iff (!rst_n)
        ale |-> t_cfg_r[CFG_MUX_POS] && data_oe && data_o == ext_addr[DATA_W-1:0];
    endproperty
    a_mux: assert property (p_mux) else $error("latch strobe without address");
    property p_gap;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_r == PH_D && t_rnw_r) |-> !data_oe;
    endproperty
    a_gap: assert property (p_gap) else $error("bus driven in tristate gap");
    c_mux_read: cover property (@(posedge sys_clk) $rose(rd_n) && t_cfg_r[CFG_MUX_POS]);
    c_demux_write: cover property (@(posedge sys_clk) $rose(wr_n) && !t_cfg_r[CFG_MUX_POS]);
    c_ready_wait: cover property (@(posedge sys_clk) state_r == PH_E && tmr_done && wait_rdy);
    c_win_ext: cover property (@(posedge sys_clk) state_r == PH_AB && ph_cyc_r == 16'h0005);
endmodule

/* File: tb/ext_mem_model.sv */
// behavioural external memory on the parallel bus: 256 words of 16 bits
// assumes bus pins are registered on sys_clk; ready is active high
`timescale 1ns/100ps
module ext_mem_model (
    input wire logic sys_clk,
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] data_o,
    input wire logic data_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] cs_n,
    input wire logic [7:0] ready_delay,
    output logic [15:0] data_i,
    output logic ready
);
    logic [15:0] mem [256];
    logic [15:0] last_r;
    logic [7:0] lat_r;
    logic [7:0] idx;
    logic mux_r;
    int low_r;
    // ----------------------------------------------------------------
    // storage, address latch and strobe counter
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'h5a, i[7:0]};
        end
        last_r = 16'h0000;
        lat_r = 8'h00;
        mux_r = 1'b0;
        low_r = 0;
    end
    always @(posedge sys_clk) begin
        if (ale) begin
            lat_r <= data_o[7:0];
            mux_r <= 1'b1;
        end else if (&cs_n) begin
            mux_r <= 1'b0;
        end
        if (!wr_n && !(&cs_n) && data_oe) begin
            mem[idx] <= data_o;
        end
        if (!rd_n) begin
            last_r <= data_i;
        end
        low_r <= (!rd_n || !wr_n) ? low_r + 1 : 0;
    end
    // shared bus needs the latched address, split bus uses the pins
    assign idx = mux_r ? lat_r : ext_addr[7:0];
    // released bus shows the inverse, so a late capture cannot pass by luck
    assign data_i = !rd_n ? mem[idx] : ~last_r;
    // slow answers hold ready low for ready_delay strobe cycles
    assign ready = (!rd_n || !wr_n) && (low_r >= ready_delay);
endmodule

/* File: tb/ext_bus_seq_tb_top.sv */
// self-checking bench for the external bus cycle sequencer
// assumes one phase time unit per sys_clk and the memory model on the far side
`timescale 1ns/100ps
module ext_bus_seq_tb_top;
    import ebc_pkg::*;
    logic sys_clk, rst_n, reg_wr, reg_rd, data_oe, ale, rd_n, wr_n, high_byte_select_n, ready;
    logic [7:0] reg_addr, ready_delay;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [23:0] ext_addr;
    logic [15:0] data_o, data_i;
    logic [15:0] shadow [256];
    logic [1:0] cs_n;
    int errors, checks_done, prev_cs;
    // ----------------------------------------------------------------
    // design, far side and clock
    // ----------------------------------------------------------------
    ext_bus_seq i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_addr(ext_addr), .data_o(data_o), .data_oe(data_oe), .data_i(data_i),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
        .high_byte_select_n(high_byte_select_n), .ready(ready));
    ext_mem_model i_mem (.sys_clk(sys_clk), .ext_addr(ext_addr), .data_o(data_o),
        .data_oe(data_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
        .ready_delay(ready_delay), .data_i(data_i), .ready(ready));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // one bus cycle, watched pin by pin; counters stay four-state on purpose
    task automatic run_cycle(input string name, input logic [14:0] cfg, input logic cs,
        input logic rnw, input logic hbs, input logic [23:0] adr, input logic [15:0] wd);
        int ab, c, d, e, f, first;
        logic [31:0] tot, slow, alec, oec, bad, rdv;
        logic lr, pr;
        ab = (cfg[0] ? 2 : 1) + ((int'(cs) != prev_cs) ? int'(cfg[2:1]) : 0);
        c = cfg[4:3];
        d = cfg[5];
        e = cfg[10:6] + 1;
        f = cfg[12:11];
        {tot, slow, alec, oec, bad} = '0;
        {lr, pr} = 2'b00;
        first = -1;
        reg_write(cs ? OFS_CFG1 : OFS_CFG0, {17'h0, cfg});
        reg_write(OFS_ADDR, {8'h00, adr});
        reg_write(OFS_WDATA, {16'h0, wd});
        reg_write(OFS_CMD, {29'h0, hbs, cs, rnw});
        for (int n = 0; n < 200; n++) begin
            #1;
            if (&cs_n) break;
            tot++;
            if (!rd_n || !wr_n) begin
                slow++;
                if (first < 0) first = n;
                pr = lr;
                lr = ready;
            end
            alec += ale;
            oec += data_oe;
            bad += (!wr_n && rnw) || (!rd_n && !rnw) || (cs_n !== ~(2'b01 << cs));
            bad += (high_byte_select_n !== !hbs) || (ale && data_o !== adr[15:0]);
            bad += (!cfg[14] && ext_addr !== adr) || (!rnw && data_oe && !ale && data_o !== wd);
            @(posedge sys_clk);
        end
        if (cfg[13]) begin
            chk({name, " stretch"}, 1, slow >= d + e);
            chk({name, " ready end"}, 1, lr === 1'b1 && (slow == d + e || pr === 1'b0));
            // ready first shows in strobe cycle ready_delay, so access waits for it
            e = (d + e > ready_delay) ? e : ready_delay + 1 - d;
        end
        chk({name, " length"}, ab + c + d + e + f, tot);
        chk({name, " strobe start"}, ab + c, first);
        chk({name, " strobe cycles"}, d + e, slow);
        chk({name, " latch cycles"}, cfg[14] ? ab : 0, alec);
        chk({name, " drive cycles"}, (cfg[14] ? ab : 0) + (rnw ? 0 : d + e + f), oec);
        chk({name, " pin faults"}, 0, bad);
        if (rnw) begin
            reg_read(OFS_RDATA, rdv);
            chk({name, " read data"}, {16'h0, shadow[adr[7:0]]}, rdv);
        end else begin
            shadow[adr[7:0]] = wd;
        end
        prev_cs = cs;
        $display("test %s done", name);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        ready_delay = 8'h28;
        errors = 0;
        checks_done = 0;
        prev_cs = -1;
        for (int i = 0; i < 256; i++) begin
            shadow[i] = {8'h5a, i[7:0]};
        end
        repeat (2) @(posedge sys_clk);
        #1;
        chk("idle pins", 1, cs_n === 2'b11 && rd_n && wr_n && !data_oe && !ale);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_read(8'hfc, rd);
        chk("unmapped read", 0, rd);
        run_cycle("plain read", 15'h0000, 0, 1, 0, 24'h123456, 16'h0);
        // ready high all along but not enabled: length must not shrink
        ready_delay = 8'h00;
        run_cycle("long write", 15'h1fff, 0, 0, 0, 24'habcd10, 16'hbeef);
        run_cycle("window change", 15'h110f, 1, 1, 0, 24'h000010, 16'h0);
        run_cycle("same window", 15'h110c, 1, 1, 0, 24'h000022, 16'h0);
        run_cycle("mux write", 15'h48b0, 1, 0, 1, 24'h000033, 16'h1234);
        run_cycle("mux read", 15'h4020, 1, 1, 0, 24'h000033, 16'h0);
        run_cycle("ready fast", 15'h2040, 0, 1, 0, 24'h000010, 16'h0);
        ready_delay = 8'h06;
        run_cycle("ready slow", 15'h2040, 0, 1, 1, 24'h000033, 16'h0);
        // second command while busy must not start another cycle
        reg_write(OFS_CFG0, 32'h0000_07c0);
        reg_write(OFS_CMD, 32'h0000_0001);
        reg_read(OFS_STATUS, rd);
        chk("busy flag", 1, rd);
        reg_write(OFS_CMD, 32'h0000_0000);
        for (int n = 0; n < 100 && !(&cs_n); n++) begin
            @(posedge sys_clk);
            #1;
            chk("no write strobe", 1, wr_n);
        end
        repeat (3) @(posedge sys_clk);
        #1;
        chk("stays idle", 2'b11, cs_n);
        reg_read(OFS_STATUS, rd);
        chk("idle flag", 0, rd);
        reg_read(OFS_CFG0, rd);
        chk("cfg readback", 32'h0000_07c0, rd);
        reg_read(OFS_ADDR, rd);
        chk("addr readback", 32'h0000_0033, rd);
        $display("test busy refusal done");
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
endmodule
